// file: lut_logic_pkg.sv
/*
  Constants, register indices and carrier types of the pin lookup-table logic.
  Assumes a 32-bit AHB-Lite bus with one word per register index.
*/
`default_nettype none

package lut_logic_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PINS   = 8'h00;
  localparam logic [7:0] IDX_MODE   = 8'h10;
  localparam logic [7:0] IDX_TABLE0 = 8'h11;
  localparam logic [7:0] IDX_TABLE1 = 8'h12;
  localparam logic [7:0] IDX_TABLE2 = 8'h13;

  // Mode field positions inside the mode register
  localparam int LOW_MODE_LSB  = 0;
  localparam int HIGH_MODE_LSB = 4;

  // Mode codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_TWO = 2'h1;

  // Reset values
  localparam logic [7:0] TABLE_RST = 8'h00;
  localparam logic [1:0] MODE_RST  = 2'h0;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  typedef struct packed {
    logic [1:0] high;
    logic [1:0] low;
  } lut_mode_t;

endpackage : lut_logic_pkg

`default_nettype wire

// file: gpio_lookup_table_logic.sv
/*
  Lookup-table logic for an eight-pin GPIO bank with an AHB-Lite register slave.
  Assumes ordinary GPIO drive arrives on GPIO_OUT/GPIO_OE and pins are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module gpio_lookup_table_logic
  import lut_logic_pkg::*;
#(
  parameter logic [1:0] UPPER_THREE_CODE = MODE_OFF,
  parameter logic [1:0] LOWER_THREE_CODE = MODE_OFF
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [7:0]  PIN_IN,
  input  wire logic [7:0]  GPIO_OUT,
  input  wire logic [7:0]  GPIO_OE,
  output logic      [7:0]  PIN_OUT,
  output logic      [7:0]  PIN_OE
);

  function automatic logic pick(input logic [7:0] table_v,
                                input logic [2:0] code);
    pick = table_v[code];
  endfunction : pick

  logic [7:0] table0_r;
  logic [7:0] table1_r;
  logic [7:0] table2_r;
  lut_mode_t  mode_r;
  pin_drive_t drive_r;
  pin_drive_t drive_nxt;
  logic       wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [31:0] rdata_nxt;
  logic       addr_ok;
  logic [7:0] addr_idx;
  logic [7:0] wdata8;
  logic       hi_two;
  logic       hi_three;
  logic       lo_two;
  logic       lo_three;
  logic       hi_two_bit;
  logic       hi_three_bit;
  logic       lo_two_bit;
  logic       lo_three_bit;

  assign addr_ok  = HSEL && HREADY && HTRANS[1];
  assign addr_idx = HADDR[9:2];
  assign wdata8   = HWDATA[7:0];

  // Disabled code never counts as a three-input selection
  assign hi_two   = mode_r.high == MODE_TWO;
  assign hi_three = (UPPER_THREE_CODE != MODE_OFF) &&
                    (mode_r.high == UPPER_THREE_CODE);
  assign lo_two   = mode_r.low == MODE_TWO;
  assign lo_three = (LOWER_THREE_CODE != MODE_OFF) &&
                    (mode_r.low == LOWER_THREE_CODE);

  assign hi_two_bit   = pick(table0_r, {1'b1, PIN_IN[5:4]});
  assign lo_two_bit   = pick(table0_r, {1'b0, PIN_IN[1:0]});
  assign hi_three_bit = pick(table1_r, PIN_IN[6:4]);
  assign lo_three_bit = pick(table2_r, PIN_IN[2:0]);

  // Address phase capture; write data lands one cycle later
  // Index is captured every cycle but only used while wr_pend_r is set
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && HWRITE;
      wr_idx_r  <= addr_idx;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      table0_r <= TABLE_RST;
      table1_r <= TABLE_RST;
      table2_r <= TABLE_RST;
    end else if (wr_pend_r) begin
      if (wr_idx_r == IDX_TABLE0) begin
        table0_r <= wdata8;
      end
      if (wr_idx_r == IDX_TABLE1) begin
        table1_r <= wdata8;
      end
      if (wr_idx_r == IDX_TABLE2) begin
        table2_r <= wdata8;
      end
    end
  end

  // Reserved mode bits are dropped on write and read as zero
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      mode_r.high <= MODE_RST;
      mode_r.low  <= MODE_RST;
    end else if (wr_pend_r && wr_idx_r == IDX_MODE) begin
      mode_r.high <= HWDATA[HIGH_MODE_LSB +: 2];
      mode_r.low  <= HWDATA[LOW_MODE_LSB +: 2];
    end
  end

  // Read mux; a write still in its data phase is forwarded so a read
  // right behind it sees the new value. Read-only and unmapped
  // indices keep their normal value, as their writes are dropped.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (addr_idx)
      IDX_PINS:   rdata_nxt[7:0] = PIN_IN;
      IDX_MODE: begin
        rdata_nxt[HIGH_MODE_LSB +: 2] = mode_r.high;
        rdata_nxt[LOW_MODE_LSB +: 2]  = mode_r.low;
      end
      IDX_TABLE0: rdata_nxt[7:0] = table0_r;
      IDX_TABLE1: rdata_nxt[7:0] = table1_r;
      IDX_TABLE2: rdata_nxt[7:0] = table2_r;
      default:    rdata_nxt = 32'h0000_0000;
    endcase
    if (wr_pend_r && wr_idx_r == addr_idx) begin
      if (addr_idx == IDX_MODE) begin
        rdata_nxt[HIGH_MODE_LSB +: 2] = HWDATA[HIGH_MODE_LSB +: 2];
        rdata_nxt[LOW_MODE_LSB +: 2]  = HWDATA[LOW_MODE_LSB +: 2];
      end else if (addr_idx == IDX_TABLE0 || addr_idx == IDX_TABLE1 ||
                   addr_idx == IDX_TABLE2) begin
        rdata_nxt[7:0] = wdata8;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      HRDATA <= 32'h0000_0000;
    end else if (addr_ok && !HWRITE) begin
      HRDATA <= rdata_nxt;
    end
  end

  // Slave never stalls and never errors
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // Table bits reach a pin only in their own mode; otherwise GPIO passes
  always_comb begin
    drive_nxt.out = GPIO_OUT;
    drive_nxt.oe  = GPIO_OE;
    if (hi_two) begin
      drive_nxt.out[6] = hi_two_bit;
      drive_nxt.oe[6]  = 1'b1;
    end else if (hi_three) begin
      drive_nxt.out[7] = hi_three_bit;
      drive_nxt.oe[7]  = 1'b1;
    end
    if (lo_two) begin
      drive_nxt.out[2] = lo_two_bit;
      drive_nxt.oe[2]  = 1'b1;
    end else if (lo_three) begin
      drive_nxt.out[3] = lo_three_bit;
      drive_nxt.oe[3]  = 1'b1;
    end
  end

  // Registered pins cost one cycle of latency but keep outputs glitch free
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      drive_r.out <= 8'h00;
      drive_r.oe  <= 8'h00;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  assign PIN_OUT = drive_r.out;
  assign PIN_OE  = drive_r.oe;

  // Pins are registered, so pin checks hold the previous cycle's inputs
  hi_two_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $past(hi_two) |-> (PIN_OUT[6] == $past(hi_two_bit)) && PIN_OE[6])
    else $error("upper two-input pin wrong");

  hi_two_only_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $past(!hi_two) |-> (PIN_OUT[6] == $past(GPIO_OUT[6])) && (PIN_OE[6] == $past(GPIO_OE[6])))
    else $error("two-input table leaked onto pin 6");

  lo_two_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $past(lo_two) |-> (PIN_OUT[2] == $past(lo_two_bit)) && PIN_OE[2])
    else $error("lower two-input pin wrong");

  lo_two_only_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $past(!lo_two) |-> (PIN_OUT[2] == $past(GPIO_OUT[2])) && (PIN_OE[2] == $past(GPIO_OE[2])))
    else $error("two-input table leaked onto pin 2");

  lo_off_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $past(mode_r.low == MODE_OFF) |->
      (PIN_OUT[3:0] == $past(GPIO_OUT[3:0])) && (PIN_OE[3:0] == $past(GPIO_OE[3:0])))
    else $error("lower nibble not plain GPIO when off");

  hi_off_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $past(mode_r.high == MODE_OFF) |->
      (PIN_OUT[7:4] == $past(GPIO_OUT[7:4])) && (PIN_OE[7:4] == $past(GPIO_OE[7:4])))
    else $error("upper nibble not plain GPIO when off");

  hi_three_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $past(hi_three) |-> (PIN_OUT[7] == $past(hi_three_bit)) && PIN_OE[7])
    else $error("upper three-input pin wrong");

  hi_three_only_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $past(!hi_three) |-> (PIN_OUT[7] == $past(GPIO_OUT[7])) && (PIN_OE[7] == $past(GPIO_OE[7])))
    else $error("upper three-input table leaked onto pin 7");

  lo_three_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $past(lo_three) |-> (PIN_OUT[3] == $past(lo_three_bit)) && PIN_OE[3])
    else $error("lower three-input pin wrong");

  lo_three_only_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $past(!lo_three) |-> (PIN_OUT[3] == $past(GPIO_OUT[3])) && (PIN_OE[3] == $past(GPIO_OE[3])))
    else $error("lower three-input table leaked onto pin 3");

  mode_reset_a: assert property (@(posedge SYS_CLK)
    !RESETN |=> mode_r.high == MODE_OFF && mode_r.low == MODE_OFF)
    else $error("mode not disabled after reset");

  // Reset clears every register and HRDATA; HREADYOUT comes out of reset high
  reset_values_a: assert property (@(posedge SYS_CLK)
    !RESETN |=> table0_r == TABLE_RST && table1_r == TABLE_RST && table2_r == TABLE_RST &&
      PIN_OUT == 8'h00 && PIN_OE == 8'h00 && HRDATA == 32'h0000_0000 && HREADYOUT)
    else $error("state not cleared by reset");

  table_write_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_pend_r && wr_idx_r == IDX_TABLE0 |=> table0_r == $past(wdata8))
    else $error("two-input table write lost");

  table1_write_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_pend_r && wr_idx_r == IDX_TABLE1 |=> table1_r == $past(wdata8))
    else $error("upper three-input table write lost");

  table2_write_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_pend_r && wr_idx_r == IDX_TABLE2 |=> table2_r == $past(wdata8))
    else $error("lower three-input table write lost");

  mode_write_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_pend_r && wr_idx_r == IDX_MODE |=>
      mode_r.high == $past(HWDATA[HIGH_MODE_LSB +: 2]) &&
      mode_r.low == $past(HWDATA[LOW_MODE_LSB +: 2]))
    else $error("mode write lost");

  // Pin readback is read only; a write there must leave all state alone
  write_ignore_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_pend_r && wr_idx_r == IDX_PINS |=>
      $stable(table0_r) && $stable(table1_r) && $stable(table2_r) && $stable(mode_r))
    else $error("write to pin readback changed state");

  table_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    addr_ok && !HWRITE && addr_idx == IDX_TABLE1 && !wr_pend_r
      |=> HRDATA == {24'h00_0000, $past(table1_r)})
    else $error("upper three-input table read wrong");

  table0_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    addr_ok && !HWRITE && addr_idx == IDX_TABLE0 && !wr_pend_r
      |=> HRDATA == {24'h00_0000, $past(table0_r)})
    else $error("two-input table read wrong");

  mode_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    addr_ok && !HWRITE && addr_idx == IDX_MODE && !wr_pend_r
      |=> HRDATA == {26'h000_0000, $past(mode_r.high), 2'h0, $past(mode_r.low)})
    else $error("mode read wrong");

  // A write still in its data phase is handed straight to a read behind it
  read_forward_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    addr_ok && !HWRITE && wr_pend_r && wr_idx_r == addr_idx && addr_idx == IDX_TABLE2
      |=> HRDATA == {24'h00_0000, $past(wdata8)})
    else $error("forwarded read wrong");

  pins_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    addr_ok && !HWRITE && addr_idx == IDX_PINS
      |=> HRDATA == {24'h00_0000, $past(PIN_IN)})
    else $error("pin readback wrong");

  unmapped_read_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    addr_ok && !HWRITE && addr_idx > IDX_TABLE2 |=> HRDATA == 32'h0000_0000)
    else $error("unmapped index read not zero");

  rdata_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !(addr_ok && !HWRITE) |=> $stable(HRDATA))
    else $error("read data changed outside a read");

  bus_okay_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    HREADYOUT && !HRESP)
    else $error("slave stalled or errored");

endmodule : gpio_lookup_table_logic

`default_nettype wire

// file: gpio_lut_partner.sv
/* Pin partner of the lookup-table logic: resolves each pin's level.
   Assumes the bench supplies the outside level of every undriven pin. */
`timescale 1ns/1ps
`default_nettype none

module gpio_lut_partner (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_level
);
  // Device wins where it drives, so lookup outputs feed back to the inputs
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : gpio_lut_partner

`default_nettype wire

// file: gpio_lookup_table_logic_bench.sv
/* Self-checking bench of the lookup-table logic over AHB-Lite.
   Assumes three-input codes of 2'h2 in both nibbles. */
`timescale 1ns/1ps
`default_nettype none

module gpio_lookup_table_logic_bench;
  import lut_logic_pkg::*;
  logic        sys_clk, resetn, hsel, hwrite, hready_out, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [7:0]  pin_in, gout, goe, pin_out, pin_oe, ext;
  int          mismatches, total_checks, cycles;

  gpio_lookup_table_logic #(.UPPER_THREE_CODE(2'h2), .LOWER_THREE_CODE(2'h2)) DUT (
    .SYS_CLK(sys_clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready_out),
    .HRDATA(hrdata), .HREADYOUT(hready_out), .HRESP(hresp), .PIN_IN(pin_in),
    .GPIO_OUT(gout), .GPIO_OE(goe), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
  gpio_lut_partner peer (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
    .pin_level(pin_in));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic results;
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge sys_clk); while (hready_out !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready_out !== 1'b1);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, idx, {24'h0, d}, rd);
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    check("register", rd, {24'h0, exp});
  endtask : rdchk

  // Two edges through the partner loop plus the output register
  task automatic pins(input logic [7:0] e, input logic [7:0] o, input logic [7:0] en);
    @(posedge sys_clk);
    ext <= e;
    gout <= o;
    goe <= en;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : pins

  task automatic t_reset;
    rdchk(IDX_MODE, 8'h00);
    rdchk(IDX_TABLE0, 8'h00);
    rdchk(IDX_TABLE1, 8'h00);
    rdchk(IDX_TABLE2, 8'h00);
    wr(8'h20, 8'hFF);
    rdchk(8'h20, 8'h00);
  endtask : t_reset

  task automatic t_two;
    logic [7:0] t;
    t = 8'hA6;
    wr(IDX_MODE, {2'h0, MODE_TWO, 2'h0, MODE_TWO});
    wr(IDX_TABLE0, t);
    rdchk(IDX_TABLE0, t);
    for (int c = 0; c < 4; c++) begin
      pins({2'h0, c[1:0], 2'h0, c[1:0]}, 8'h00, 8'h00);
      check("pin6", {31'h0, pin_out[6]}, {31'h0, t[4 + c]});
      check("pin2", {31'h0, pin_out[2]}, {31'h0, t[c]});
      check("oe62", {30'h0, pin_oe[6], pin_oe[2]}, 32'h3);
    end
  endtask : t_two

  task automatic t_three;
    logic [7:0] up;
    logic [7:0] lo;
    up = 8'h5C;
    lo = 8'h93;
    wr(IDX_MODE, 8'h22);
    wr(IDX_TABLE1, up);
    wr(IDX_TABLE2, lo);
    rdchk(IDX_TABLE1, up);
    rdchk(IDX_TABLE2, lo);
    for (int c = 0; c < 8; c++) begin
      pins({1'b0, c[2:0], 1'b0, c[2:0]}, 8'h00, 8'h00);
      check("pin7", {31'h0, pin_out[7]}, {31'h0, up[c]});
      check("pin3", {31'h0, pin_out[3]}, {31'h0, lo[c]});
      check("oe73", {30'h0, pin_oe[7], pin_oe[3]}, 32'h3);
    end
  endtask : t_three

  task automatic t_iso;
    wr(IDX_TABLE0, 8'hFF);
    wr(IDX_TABLE1, 8'hFF);
    wr(IDX_TABLE2, 8'hFF);
    wr(IDX_MODE, 8'h11);
    pins(8'h00, 8'h00, 8'hFF);
    check("pin73", {30'h0, pin_out[7], pin_out[3]}, 32'h0);
    wr(IDX_MODE, 8'h22);
    pins(8'h00, 8'h00, 8'hFF);
    check("pin62", {30'h0, pin_out[6], pin_out[2]}, 32'h0);
    wr(IDX_MODE, 8'h00);
    pins(8'h00, 8'h5A, 8'hFF);
    check("gpio", {24'h0, pin_out}, 32'h5A);
    check("gpio_oe", {24'h0, pin_oe}, 32'hFF);
    wr(IDX_MODE, 8'hFF);
    rdchk(IDX_MODE, 8'h33);
    pins(8'h00, 8'hA5, 8'hFF);
    check("gpio3", {24'h0, pin_out}, 32'hA5);
    check("gpio3_oe", {24'h0, pin_oe}, 32'hFF);
  endtask : t_iso

  // Write then read of one index with no idle cycle between
  task automatic b2b(input logic [7:0] idx, input logic [7:0] d, input logic [7:0] exp);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge sys_clk); while (hready_out !== 1'b1);
    hwrite <= 1'b0;
    hwdata <= {24'h0, d};
    do @(posedge sys_clk); while (hready_out !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    do @(posedge sys_clk); while (hready_out !== 1'b1);
    check("forwarded", hrdata, {24'h0, exp});
  endtask : b2b

  task automatic t_b2b;
    b2b(IDX_TABLE2, 8'h3C, 8'h3C);
    rdchk(IDX_TABLE2, 8'h3C);
    b2b(IDX_PINS, 8'h00, 8'hA5);
  endtask : t_b2b

  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    ext = 8'h00;
    gout = 8'h00;
    goe = 8'h00;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_two();
    t_three();
    t_iso();
    t_b2b();
    results();
  end
endmodule : gpio_lookup_table_logic_bench

`default_nettype wire
